// *** design/clk_out_gate.sv ***
// per-output run decision from the software enable bit and the active-low pin
// assumes pins are synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module clk_out_gate #(
   parameter int unsigned N_OUT = 7
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [N_OUT-1:0] enable_bits_in,
   input wire logic [N_OUT-1:0] oe_n_pins_in,
   output logic [N_OUT-1:0] run_out
);

   typedef struct packed {
      logic [N_OUT-1:0] run;
   } gate_t;

   gate_t s_q;
   gate_t s_d;
   logic [N_OUT-1:0] run_next;

   if (N_OUT < 1 || N_OUT > 32) begin : g_bad_n_out
      $error("clk_out_gate: N_OUT out of range");
   end

   // a cleared bit parks the pair low whatever the pin says
   for (genvar g = 0; g < N_OUT; g++) begin : g_out
      assign run_next[g] = enable_bits_in[g] & ~oe_n_pins_in[g];
   end

   always_comb begin
      s_d = s_q;
      s_d.run = run_next;
   end

   // parked low out of reset until the first decision
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s_q <= '0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end

   assign run_out = s_q.run;

endmodule
`default_nettype wire

// *** design/clkbuf_reg_bank.sv ***
// indexed configuration and identity byte bank of a seven-output clock fanout buffer
// assumes a serial engine that strobes address, received bytes, send requests and stop
// Operation
// - a cleared enable bit holds that output pair low on both legs whatever its pin says.
// - output 6 enable is bit 5 of byte 1, read/write, default 1, and clearing it forces it low.
// - byte 1 bits 1:0 select swing, default 10, codes 00 0.55V, 01 0.65V, 10 0.7V, 11 0.8V.
// - byte 2 bits 0,2,3,4,6,7 are read/write edge speeds of outputs 0 to 5, default fast.
// - byte 3 bit 0 is the read/write edge speed of output 6, default fast, rest reserved.
// - byte 4 is reserved and always reads all ones.
// - byte 5 returns fixed revision code high and maker code low, unchanged by writes.
// - byte 6 returns fixed class code in bits 7:6 and part code in bits 5:0.
// - byte 7 bits 4:0 set the block read length, default 8, bits 7:5 read zero.
// - a block write is address, index, count then data bytes, each acknowledged.
// - a block read sends the count then data from the stored index after a read address.
// - byte 0 bits 0,2,3,4,6,7 are read/write enables of outputs 0 to 5, all bits default 1.
`timescale 1ns/10ps
`default_nettype none
module clkbuf_reg_bank
   import clkbuf_regs_pkg::*;
#(
   parameter logic [3:0] REV_CODE = clkbuf_regs_pkg::REV_CODE_DFLT,
   parameter logic [3:0] MAKER_CODE = clkbuf_regs_pkg::MAKER_CODE_DFLT,
   parameter logic [1:0] CLASS_CODE = clkbuf_regs_pkg::CLASS_CODE_DFLT,
   parameter logic [5:0] PART_CODE = clkbuf_regs_pkg::PART_CODE_DFLT
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CE_IN,
   input wire logic ADDR_STB_IN,
   input wire logic RNW_IN,
   input wire logic RX_STB_IN,
   input wire logic [7:0] RX_BYTE_IN,
   input wire logic TX_REQ_IN,
   input wire logic STOP_IN,
   input wire logic [clkbuf_regs_pkg::NUM_OUTS-1:0] OE_N_IN,
   output logic ACK_OUT,
   output logic TX_VALID_OUT,
   output logic [7:0] TX_BYTE_OUT,
   output logic [clkbuf_regs_pkg::NUM_OUTS-1:0] CLK_EN_OUT,
   output logic [clkbuf_regs_pkg::NUM_OUTS-1:0] SLEW_FAST_OUT,
   output logic [clkbuf_regs_pkg::SWING_W-1:0] SWING_SEL_OUT
);

   import clkbuf_regs_pkg::*;

   typedef struct packed {
      bank_state_t st;
      logic [7:0] idx;
      logic [7:0] wr_left;
      logic [LEN_W-1:0] rd_left;
      logic [7:0] enable_low;
      logic [7:0] en6_swing;
      logic [7:0] speed_low;
      logic [7:0] speed_high;
      logic [7:0] readback_length;
      logic [NUM_OUTS-1:0] slew;
      logic [SWING_W-1:0] swing;
      logic ack;
      logic [7:0] tx;
      logic tx_v;
   } bank_t;

   localparam bank_t BANK_RST = '{
      st: ST_IDLE,
      idx: 8'h00,
      wr_left: 8'h00,
      rd_left: 5'h00,
      enable_low: ENABLE_LOW_RST,
      en6_swing: EN6_SWING_RST,
      speed_low: SPEED_LOW_RST,
      speed_high: SPEED_HIGH_RST,
      readback_length: READBACK_LEN_RST,
      slew: 7'h7f,
      swing: 2'h2,
      ack: 1'b0,
      tx: 8'h00,
      tx_v: 1'b0
   };

   bank_t s_q;
   bank_t s_d;
   logic [NUM_OUTS-1:0] enable_bits;

   // the byte layout below assumes six low outputs plus output 6, all inside one byte
   if (LOW_OUTS + 1 != NUM_OUTS || LEN_W > 8 || SWING_LSB + SWING_W > 8 ||
       OUT6_EN_BIT > 7 || SPEED6_BIT > 7) begin : g_bad_layout
      $error("clkbuf_reg_bank: register layout constants do not fit a byte");
   end
   for (genvar g = 0; g < LOW_OUTS; g++) begin : g_pos_check
      if (LOW_BIT_POS[g] > 7) begin : g_bad_pos
         $error("clkbuf_reg_bank: output bit position outside the byte");
      end
   end

   // merge only the writable bits, so reserved and fixed bits keep their value
   function automatic logic [7:0] masked(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] wmask);
      masked = (old_v & ~wmask) | (new_v & wmask);
   endfunction

   // spread the six low-output bits of an enable or speed byte plus output 6
   function automatic logic [NUM_OUTS-1:0] pick(input logic [7:0] low_byte,
                                                input logic bit6);
      logic [NUM_OUTS-1:0] v;
      v = '0;
      for (int i = 0; i < LOW_OUTS; i++) begin
         v[i] = low_byte[LOW_BIT_POS[i]];
      end
      v[NUM_OUTS-1] = bit6;
      pick = v;
   endfunction

   function automatic logic [7:0] read_byte(input bank_t s, input logic [7:0] i);
      logic [7:0] v;
      v = UNMAPPED_VAL;
      if (i == OFS_ENABLE_LOW) begin
         v = s.enable_low;
      end else if (i == OFS_EN6_SWING) begin
         v = s.en6_swing;
      end else if (i == OFS_SPEED_LOW) begin
         v = s.speed_low;
      end else if (i == OFS_SPEED_HIGH) begin
         v = s.speed_high;
      end else if (i == OFS_RSVD_ONES) begin
         v = RSVD_ONES_VAL;
      end else if (i == OFS_REV_MAKER) begin
         v = {REV_CODE, MAKER_CODE};
      end else if (i == OFS_PART) begin
         v = {CLASS_CODE, PART_CODE};
      end else if (i == OFS_READBACK_LEN) begin
         v = s.readback_length;
      end
      read_byte = v;
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.tx_v = 1'b0;

      // settings follow the stored bytes one cycle later
      s_d.slew = pick(s_q.speed_low, s_q.speed_high[SPEED6_BIT]);
      s_d.swing = s_q.en6_swing[SWING_LSB +: SWING_W];

      if (STOP_IN) begin
         // stop ends any transfer; the index stays for a later read
         s_d.st = ST_IDLE;
      end else if (ADDR_STB_IN) begin
         s_d.ack = 1'b1;
         if (RNW_IN) begin
            s_d.st = ST_SEND_COUNT;
         end else begin
            s_d.st = ST_GET_INDEX;
         end
      end else if (RX_STB_IN) begin
         case (s_q.st)
            ST_GET_INDEX: begin
               s_d.ack = 1'b1;
               s_d.idx = RX_BYTE_IN;
               s_d.st = ST_GET_COUNT;
            end
            ST_GET_COUNT: begin
               s_d.ack = 1'b1;
               s_d.wr_left = RX_BYTE_IN;
               s_d.st = ST_WRITE_DATA;
            end
            ST_WRITE_DATA: begin
               // bytes beyond the announced count are still acknowledged but dropped
               s_d.ack = 1'b1;
               if (s_q.wr_left != 8'h00) begin
                  s_d.wr_left = s_q.wr_left - 8'h01;
                  s_d.idx = s_q.idx + 8'h01;
                  if (s_q.idx == OFS_ENABLE_LOW) begin
                     s_d.enable_low = masked(s_q.enable_low, RX_BYTE_IN,
                                             ENABLE_LOW_WMASK);
                  end else if (s_q.idx == OFS_EN6_SWING) begin
                     s_d.en6_swing = masked(s_q.en6_swing, RX_BYTE_IN,
                                            EN6_SWING_WMASK);
                  end else if (s_q.idx == OFS_SPEED_LOW) begin
                     s_d.speed_low = masked(s_q.speed_low, RX_BYTE_IN,
                                            SPEED_LOW_WMASK);
                  end else if (s_q.idx == OFS_SPEED_HIGH) begin
                     s_d.speed_high = masked(s_q.speed_high, RX_BYTE_IN,
                                             SPEED_HIGH_WMASK);
                  end else if (s_q.idx == OFS_READBACK_LEN) begin
                     s_d.readback_length = masked(s_q.readback_length, RX_BYTE_IN,
                                                  READBACK_LEN_WMASK);
                  end
                  // bytes 4 to 6 and unmapped indices take the write and keep their value
               end
            end
            default: begin
               // not addressed for writing: no acknowledge
               s_d.ack = 1'b0;
            end
         endcase
      end else if (TX_REQ_IN) begin
         case (s_q.st)
            ST_SEND_COUNT: begin
               s_d.tx = s_q.readback_length;
               s_d.tx_v = 1'b1;
               s_d.rd_left = s_q.readback_length[LEN_W-1:0];
               s_d.st = ST_SEND_DATA;
            end
            ST_SEND_DATA: begin
               // a host reading past the count gets filler rather than a stall
               s_d.tx_v = 1'b1;
               if (s_q.rd_left != '0) begin
                  s_d.tx = read_byte(s_q, s_q.idx);
                  s_d.idx = s_q.idx + 8'h01;
                  s_d.rd_left = s_q.rd_left - 5'h01;
               end else begin
                  s_d.tx = PAST_END_VAL;
               end
            end
            default: begin
               s_d.tx_v = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         s_q <= BANK_RST;
      end else if (CE_IN) begin
         s_q <= s_d;
      end
   end

   assign enable_bits = pick(s_q.enable_low, s_q.en6_swing[OUT6_EN_BIT]);

   clk_out_gate #(
      .N_OUT(NUM_OUTS)
   ) u_gate (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .ce_in(CE_IN),
      .enable_bits_in(enable_bits),
      .oe_n_pins_in(OE_N_IN),
      .run_out(CLK_EN_OUT)
   );

   assign ACK_OUT = s_q.ack;
   assign TX_VALID_OUT = s_q.tx_v;
   assign TX_BYTE_OUT = s_q.tx;
   assign SLEW_FAST_OUT = s_q.slew;
   assign SWING_SEL_OUT = s_q.swing;

endmodule
`default_nettype wire

// *** include/clkbuf_regs_pkg.sv ***
// constants, types and reset values for the clock buffer configuration bank
// assumes a byte-level serial engine outside that reports address, data and stop events
package clkbuf_regs_pkg;

   // register indices
   localparam logic [7:0] OFS_ENABLE_LOW = 8'h00;
   localparam logic [7:0] OFS_EN6_SWING = 8'h01;
   localparam logic [7:0] OFS_SPEED_LOW = 8'h02;
   localparam logic [7:0] OFS_SPEED_HIGH = 8'h03;
   localparam logic [7:0] OFS_RSVD_ONES = 8'h04;
   localparam logic [7:0] OFS_REV_MAKER = 8'h05;
   localparam logic [7:0] OFS_PART = 8'h06;
   localparam logic [7:0] OFS_READBACK_LEN = 8'h07;

   // outputs 0..5 share this bit placement in the enable and edge-speed bytes
   localparam int unsigned LOW_OUTS = 6;
   localparam int unsigned LOW_BIT_POS [0:5] = '{0, 2, 3, 4, 6, 7};
   localparam int unsigned OUT6_EN_BIT = 5;
   localparam int unsigned SPEED6_BIT = 0;
   localparam int unsigned SWING_LSB = 0;
   localparam int unsigned SWING_W = 2;
   localparam int unsigned LEN_W = 5;
   localparam int unsigned NUM_OUTS = 7;

   // reset values, reserved bits included
   localparam logic [7:0] ENABLE_LOW_RST = 8'hff;
   localparam logic [7:0] EN6_SWING_RST = 8'h6e;
   localparam logic [7:0] SPEED_LOW_RST = 8'hff;
   localparam logic [7:0] SPEED_HIGH_RST = 8'hc5;
   localparam logic [7:0] RSVD_ONES_VAL = 8'hff;
   localparam logic [7:0] READBACK_LEN_RST = 8'h08;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;
   localparam logic [7:0] PAST_END_VAL = 8'hff;

   // writable bits per byte; all others keep their value
   localparam logic [7:0] ENABLE_LOW_WMASK = 8'hdd;
   localparam logic [7:0] EN6_SWING_WMASK = 8'h23;
   localparam logic [7:0] SPEED_LOW_WMASK = 8'hdd;
   localparam logic [7:0] SPEED_HIGH_WMASK = 8'h01;
   localparam logic [7:0] READBACK_LEN_WMASK = 8'h1f;

   // identity defaults; the values are arbitrary
   localparam logic [3:0] REV_CODE_DFLT = 4'h2;
   localparam logic [3:0] MAKER_CODE_DFLT = 4'h5;
   localparam logic [1:0] CLASS_CODE_DFLT = 2'h2;
   localparam logic [5:0] PART_CODE_DFLT = 6'h2a;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_GET_INDEX,
      ST_GET_COUNT,
      ST_WRITE_DATA,
      ST_SEND_COUNT,
      ST_SEND_DATA
   } bank_state_t;

endpackage

// *** testbench/clkbuf_host_model.sv ***
// host controller model issuing indexed block transfers as byte events
// assumes the bank answers one cycle after each strobe
`timescale 1ns/10ps
`default_nettype none
module clkbuf_host_model (
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_byte_in,
   output logic addr_stb_out,
   output logic rnw_out,
   output logic rx_stb_out,
   output logic [7:0] rx_byte_out,
   output logic tx_req_out,
   output logic stop_out
);
   int acks = 0;
   logic [7:0] got_q[$];
   initial {addr_stb_out, rnw_out, rx_stb_out, rx_byte_out, tx_req_out, stop_out} = '0;
   always @(posedge clk_in) begin
      if (ack_in) acks++;
      if (tx_valid_in) got_q.push_back(tx_byte_in);
   end
   // one event a cycle: addr, rnw, rx, tx, stop; an unstrobed data line toggles
   task automatic ev(input logic [4:0] k, input logic [7:0] b);
      @(posedge clk_in);
      #1;
      {addr_stb_out, rnw_out, rx_stb_out, tx_req_out, stop_out} = k;
      rx_byte_out = k[2] ? b : ~rx_byte_out;
   endtask
   // address, index, count, data bytes, stop
   task automatic wr(input logic [7:0] idx, input logic [7:0] cnt, input logic [7:0] d[$]);
      ev(5'h10, 8'h00);
      ev(5'h04, idx);
      ev(5'h04, cnt);
      foreach (d[i]) ev(5'h04, d[i]);
      ev(5'h01, 8'h00);
      ev(5'h00, 8'h00);
   endtask
   // index write, repeated address for read, n requests, stop
   task automatic rd(input logic [7:0] idx, input int n);
      got_q.delete();
      ev(5'h10, 8'h00);
      ev(5'h04, idx);
      ev(5'h18, 8'h00);
      repeat (n) ev(5'h02, 8'h00);
      ev(5'h01, 8'h00);
      ev(5'h00, 8'h00);
   endtask
endmodule
`default_nettype wire

// *** testbench/clkbuf_reg_bank_sva.sv ***
// checker for the configuration bank byte-event port and output levels
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module clkbuf_reg_bank_sva (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CE_IN,
   input wire logic ADDR_STB_IN,
   input wire logic RNW_IN,
   input wire logic RX_STB_IN,
   input wire logic [7:0] RX_BYTE_IN,
   input wire logic TX_REQ_IN,
   input wire logic STOP_IN,
   input wire logic [clkbuf_regs_pkg::NUM_OUTS-1:0] OE_N_IN,
   input wire logic ACK_OUT,
   input wire logic TX_VALID_OUT,
   input wire logic [7:0] TX_BYTE_OUT,
   input wire logic [clkbuf_regs_pkg::NUM_OUTS-1:0] CLK_EN_OUT,
   input wire logic [clkbuf_regs_pkg::NUM_OUTS-1:0] SLEW_FAST_OUT,
   input wire logic [clkbuf_regs_pkg::SWING_W-1:0] SWING_SEL_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   a_addr_acked: assert property (CE_IN && ADDR_STB_IN && !STOP_IN |=> ACK_OUT)
      else $error("address strobe not acknowledged");
   a_ack_has_cause: assert property (
      ACK_OUT |-> $past(CE_IN && (ADDR_STB_IN || RX_STB_IN)))
      else $error("acknowledge without a strobe");
   a_stop_quiet: assert property (CE_IN && STOP_IN |=> !ACK_OUT && !TX_VALID_OUT)
      else $error("answer to a stop");
   a_tx_has_cause: assert property (TX_VALID_OUT |-> $past(CE_IN && TX_REQ_IN))
      else $error("byte sent without request");
   a_txbyte_holds: assert property (!TX_VALID_OUT |-> $stable(TX_BYTE_OUT))
      else $error("send byte changed unasked");
   a_pin_gates: assert property (
      $past(RESETN_IN && CE_IN) |-> (CLK_EN_OUT & $past(OE_N_IN)) == '0)
      else $error("output runs with its pin high");
   a_reset_levels: assert property ($rose(RESETN_IN) |->
      SWING_SEL_OUT == 2'h2 && SLEW_FAST_OUT == 7'h7f && CLK_EN_OUT == 7'h00)
      else $error("wrong levels after reset");
   a_ce_freezes: assert property (
      !CE_IN |=> $stable(SLEW_FAST_OUT) && $stable(SWING_SEL_OUT))
      else $error("outputs moved while clock enable low");
endmodule
bind clkbuf_reg_bank clkbuf_reg_bank_sva u_clkbuf_reg_bank_sva (.CLK_IN(CLK_IN),
   .RESETN_IN(RESETN_IN), .CE_IN(CE_IN), .ADDR_STB_IN(ADDR_STB_IN), .RNW_IN(RNW_IN),
   .RX_STB_IN(RX_STB_IN), .RX_BYTE_IN(RX_BYTE_IN), .TX_REQ_IN(TX_REQ_IN), .STOP_IN(STOP_IN),
   .OE_N_IN(OE_N_IN), .ACK_OUT(ACK_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_BYTE_OUT(TX_BYTE_OUT),
   .CLK_EN_OUT(CLK_EN_OUT), .SLEW_FAST_OUT(SLEW_FAST_OUT), .SWING_SEL_OUT(SWING_SEL_OUT));
`default_nettype wire

// *** testbench/clock_buffer_smbus_register_bank_tb.sv ***
// self-checking bench for the configuration bank, driven through the host model
// assumes the bank's default identity parameters
`timescale 1ns/10ps
`default_nettype none
module clock_buffer_smbus_register_bank_tb;
   import clkbuf_regs_pkg::*;
   logic clk = 0, rstn = 0, ce = 1;
   logic [6:0] oe_n = 7'h05;
   logic adr, rnw, rx, tx, stp, ack, txv;
   logic [7:0] rxb, txb;
   logic [6:0] clk_en, slew;
   logic [1:0] swing;
   int bad_count = 0, num_checks = 0, cyc = 0;
   int acks0 = 0, got0 = 0;
   localparam logic [7:0] ID_REV_MAKER = {REV_CODE_DFLT, MAKER_CODE_DFLT};
   localparam logic [7:0] ID_PART = {CLASS_CODE_DFLT, PART_CODE_DFLT};
   initial forever #20 clk = ~clk;
   clkbuf_reg_bank u_clkbuf_reg_bank (.CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce),
      .ADDR_STB_IN(adr), .RNW_IN(rnw), .RX_STB_IN(rx), .RX_BYTE_IN(rxb), .TX_REQ_IN(tx),
      .STOP_IN(stp), .OE_N_IN(oe_n), .ACK_OUT(ack), .TX_VALID_OUT(txv), .TX_BYTE_OUT(txb),
      .CLK_EN_OUT(clk_en), .SLEW_FAST_OUT(slew), .SWING_SEL_OUT(swing));
   clkbuf_host_model u_clkbuf_host_model (.clk_in(clk), .ack_in(ack), .tx_valid_in(txv),
      .tx_byte_in(txb), .addr_stb_out(adr), .rnw_out(rnw), .rx_stb_out(rx),
      .rx_byte_out(rxb), .tx_req_out(tx), .stop_out(stp));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a missing byte reads as unknown and fails the compare
   task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e[$]);
      u_clkbuf_host_model.rd(idx, e.size());
      foreach (e[i]) chk(u_clkbuf_host_model.got_q[i], e[i]);
   endtask
   task automatic summarize;
      if (bad_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         $display("Error %0t: timeout", $time);
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rstn = 1;
      ce = 0;
      repeat (3) @(posedge clk);
      #1;
      ce = 1;
      chk_rd(8'h00, {8'h08, 8'hff, 8'h6e, 8'hff, 8'hc5, 8'hff,
         ID_REV_MAKER, ID_PART, 8'h08});
      chk(8'(u_clkbuf_host_model.acks), 8'h03);
      chk({6'h00, swing}, 8'h02);
      chk({1'b0, slew}, 8'h7f);
      chk({1'b0, clk_en}, {1'b0, ~oe_n});
      u_clkbuf_host_model.wr(8'h00, 8'h08,
         {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he3});
      chk(8'(u_clkbuf_host_model.acks), 8'h0e);
      chk({6'h00, swing}, 8'h00);
      chk({1'b0, slew}, 8'h00);
      chk({1'b0, clk_en}, 8'h00);
      chk_rd(8'h00, {8'h03, 8'h22, 8'h4c, 8'h22, 8'hff});
      chk_rd(8'h04, {8'h03, 8'hff, ID_REV_MAKER, ID_PART});
      for (int c = 0; c < 4; c++) begin
         oe_n[6] = c[0];
         u_clkbuf_host_model.wr(8'h01, 8'h01, {8'h20 | 8'(c), 8'h00});
         chk({6'h00, swing}, 8'(c));
         chk({1'b0, clk_en}, {1'b0, ~c[0], 6'h00});
      end
      chk_rd(8'h01, {8'h03, 8'h6f, 8'h22, 8'hc4});
      chk_rd(8'h07, {8'h03, 8'h03, 8'h00, 8'h00});
      // a stray byte or send request outside a transfer gets no answer
      acks0 = u_clkbuf_host_model.acks;
      got0 = u_clkbuf_host_model.got_q.size();
      u_clkbuf_host_model.ev(5'h04, 8'h55);
      u_clkbuf_host_model.ev(5'h02, 8'h00);
      u_clkbuf_host_model.ev(5'h00, 8'h00);
      u_clkbuf_host_model.ev(5'h00, 8'h00);
      chk(8'(u_clkbuf_host_model.acks - acks0), 8'h00);
      chk(8'(u_clkbuf_host_model.got_q.size() - got0), 8'h00);
      // with the clock enable low a whole write is ignored
      ce = 0;
      u_clkbuf_host_model.wr(8'h01, 8'h01, {8'h20});
      ce = 1;
      chk(8'(u_clkbuf_host_model.acks - acks0), 8'h00);
      chk({6'h00, swing}, 8'h03);
      // a mid-run reset brings back the defaults
      rstn = 0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1;
      chk_rd(8'h01, {8'h08, 8'h6e});
      chk({6'h00, swing}, 8'h02);
      chk({1'b0, clk_en}, {1'b0, ~oe_n});
      summarize();
   end
endmodule
`default_nettype wire
